/* hw/wrcb_bank.v */
// wake and radio configuration bank: byte registers, wake counter, listen timer, irq gating
// assumes a byte-wide register port from the serial control port logic on the same clock,
// and event levels from the command processor, battery monitor and wake timer, all on clk
// all event inputs come from logic on clk, so none passes a synchroniser here
// the wake timer line idles low; its rising edge counts one expiry
// Notes on behaviour
// - mask1 bit 7 lets a low battery raise the interrupt.
// - mask1 bit 6 lets command-ready raise the interrupt, following the status flag.
// - mask1 bit 4 lets each wake timer expiry raise the interrupt.
// - mask1 bit 1 lets serial port ready raise the interrupt.
// - mask1 bit 0 lets command completion raise the interrupt.
// - mask bit one passes its source, zero suppresses it.
// - sixteen-bit wake count in two bytes, host may load it to zero.
// - count above limit wakes to radio idle and raises limit interrupt if enabled.
// - smart wake powers radio receiving on stored channel for listen period.
// - no preamble before listen period ends returns device to sleep.
// - listen period is value times tick of 128 times divider reference cycles.
// - signal level limit in dBm is register value minus 107.
// - carrier is 24-bit word over three bytes, 26 MHz times word over 65536.
// - bit rate is 12-bit word times 100, low eight bits in one register.
// - upper four rate bits sit in bits 3 to 0 of next register.
// - mask0 bit 7 enables the wake limit interrupt.
`timescale 1ns/10ps
`default_nettype none
`include "wrcb_map.vh"

module wrcb_bank (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [9:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  output wire regHit,
  // event sources
  input wire batteryLow,
  input wire cmdReady,
  input wire portReady,
  input wire cmdDone,
  input wire wakeTimerExpiry,
  input wire smartWakeEn,
  input wire preambleFound,
  // radio control
  output reg radioRxOn,
  output reg radioIdleWake,
  output reg sleepReq,
  output wire irqOut,
  // configuration words
  output wire [23:0] carrierWord,
  output wire [11:0] bitRateWord,
  output wire signed [8:0] levelLimitDbm
);

  // reference cycles to clock cycles: 250 MHz over 6.5 MHz, scaled by 128 per divider unit
  localparam [31:0] TICK_UNIT_CYC =
    (`WRCB_TICK_REF_CYCLES * `WRCB_CLK_KHZ) / `WRCB_REF_KHZ;
  localparam [2:0] ST_SLEEP = 3'b001;
  localparam [2:0] ST_LISTEN = 3'b010;
  localparam [2:0] ST_IDLE = 3'b100;

  // configuration storage
  reg [7:0] mask0_reg;
  reg [7:0] mask1_reg;
  reg [15:0] wakeCount_reg;
  reg [15:0] wakeLimit_reg;
  reg [7:0] listenPeriod_reg;
  reg [7:0] tickDiv_reg;
  reg [7:0] levelLimit_reg;
  reg [23:0] carrier_reg;
  reg [11:0] rate_reg;
  reg [3:0] rateHiRest_reg;
  // sequencing and listen timers
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [31:0] unitCnt_reg;
  reg [7:0] tickCnt_reg;
  reg [7:0] dwellCnt_reg;
  reg expiryPrev_reg;
  reg limitHit_reg;

  // write decode helper
  function wrHit;
    input [9:0] a;
    input [9:0] target;
    begin
      wrHit = regWrite && (a == target);
    end
  endfunction

  // counter step test, one bit wider so a count of 255 cannot wrap; zero acts as one
  function stepReached;
    input [7:0] cnt;
    input [7:0] limit;
    begin
      stepReached = (({1'b0, cnt} + 9'h001) >= {1'b0, limit});
    end
  endfunction

  // wake limit test: the new count must exceed the threshold
  function overLimit;
    input [15:0] cnt;
    input [15:0] limit;
    begin
      overLimit = (cnt > limit);
    end
  endfunction

  wire expiryPulse = wakeTimerExpiry && !expiryPrev_reg;
  wire [15:0] countPlus = wakeCount_reg + 16'h0001;
  wire limitReach = expiryPulse && overLimit(countPlus, wakeLimit_reg);
  wire countWrite = wrHit(regAddr, `WRCB_WCNT_LO_ADDR)
    || wrHit(regAddr, `WRCB_WCNT_HI_ADDR);
  wire tickDone = (unitCnt_reg >= TICK_UNIT_CYC - 32'd1);
  wire dwellEnd = tickDone && stepReached(tickCnt_reg, tickDiv_reg)
    && stepReached(dwellCnt_reg, listenPeriod_reg);

  assign carrierWord = carrier_reg;
  assign bitRateWord = rate_reg;
  assign levelLimitDbm = $signed({1'b0, levelLimit_reg}) - 9'sd107;

  // interrupt: each source gated by its mask bit
  assign irqOut = (mask1_reg[`WRCB_M1_BATTERY] & batteryLow)
    | (mask1_reg[`WRCB_M1_CMD_READY] & cmdReady)
    | (mask1_reg[`WRCB_M1_WAKE_TIMER] & wakeTimerExpiry)
    | (mask1_reg[`WRCB_M1_PORT_READY] & portReady)
    | (mask1_reg[`WRCB_M1_CMD_DONE] & cmdDone)
    | (mask0_reg[`WRCB_M0_WAKE_LIMIT] & limitHit_reg);

  // wake timer edge detector, idle low like the event line
  always @(posedge clk) begin
    if (rst) begin
      expiryPrev_reg <= 1'b0;
    end else begin
      expiryPrev_reg <= wakeTimerExpiry;
    end
  end

  // first interrupt mask, only the wake limit bit has a source here
  always @(posedge clk) begin
    if (rst) begin
      mask0_reg <= `WRCB_RESET_BYTE;
    end else if (wrHit(regAddr, `WRCB_IRQ_MASK0_ADDR)) begin
      mask0_reg <= regWdata;
    end
  end

  // second interrupt mask, reserved bits held at zero
  always @(posedge clk) begin
    if (rst) begin
      mask1_reg <= `WRCB_RESET_BYTE;
    end else if (wrHit(regAddr, `WRCB_IRQ_MASK1_ADDR)) begin
      mask1_reg <= regWdata & `WRCB_M1_WRITABLE;
    end
  end

  // wake count: an expiry in the same cycle as a byte write wins
  always @(posedge clk) begin
    if (rst) begin
      wakeCount_reg <= 16'h0000;
    end else if (expiryPulse) begin
      wakeCount_reg <= countPlus;
    end else begin
      if (wrHit(regAddr, `WRCB_WCNT_LO_ADDR)) wakeCount_reg[7:0] <= regWdata;
      if (wrHit(regAddr, `WRCB_WCNT_HI_ADDR)) wakeCount_reg[15:8] <= regWdata;
    end
  end

  // wake limit, two independent bytes
  always @(posedge clk) begin
    if (rst) begin
      wakeLimit_reg <= 16'h0000;
    end else begin
      if (wrHit(regAddr, `WRCB_WLIM_LO_ADDR)) wakeLimit_reg[7:0] <= regWdata;
      if (wrHit(regAddr, `WRCB_WLIM_HI_ADDR)) wakeLimit_reg[15:8] <= regWdata;
    end
  end

  // listen period in ticks
  always @(posedge clk) begin
    if (rst) begin
      listenPeriod_reg <= `WRCB_RESET_BYTE;
    end else if (wrHit(regAddr, `WRCB_LISTEN_ADDR)) begin
      listenPeriod_reg <= regWdata;
    end
  end

  // listen tick divider
  always @(posedge clk) begin
    if (rst) begin
      tickDiv_reg <= `WRCB_RESET_BYTE;
    end else if (wrHit(regAddr, `WRCB_TICKDIV_ADDR)) begin
      tickDiv_reg <= regWdata;
    end
  end

  // signal level limit
  always @(posedge clk) begin
    if (rst) begin
      levelLimit_reg <= `WRCB_RESET_BYTE;
    end else if (wrHit(regAddr, `WRCB_LEVEL_ADDR)) begin
      levelLimit_reg <= regWdata;
    end
  end

  // carrier word, three independent bytes, no latching
  always @(posedge clk) begin
    if (rst) begin
      carrier_reg <= 24'h000000;
    end else begin
      if (wrHit(regAddr, `WRCB_CARRIER0_ADDR)) carrier_reg[7:0] <= regWdata;
      if (wrHit(regAddr, `WRCB_CARRIER1_ADDR)) carrier_reg[15:8] <= regWdata;
      if (wrHit(regAddr, `WRCB_CARRIER2_ADDR)) carrier_reg[23:16] <= regWdata;
    end
  end

  // rate word: low byte, nibble of the next byte, upper nibble kept for readback
  always @(posedge clk) begin
    if (rst) begin
      rate_reg <= 12'h000;
      rateHiRest_reg <= 4'h0;
    end else begin
      if (wrHit(regAddr, `WRCB_RATE_LO_ADDR)) rate_reg[7:0] <= regWdata;
      if (wrHit(regAddr, `WRCB_RATE_HI_ADDR)) begin
        rate_reg[11:8] <= regWdata[3:0];
        rateHiRest_reg <= regWdata[7:4];
      end
    end
  end

  // read multiplexer, registered data
  always @(posedge clk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `WRCB_IRQ_MASK0_ADDR: regRdata <= mask0_reg;
        `WRCB_IRQ_MASK1_ADDR: regRdata <= mask1_reg;
        `WRCB_WCNT_LO_ADDR: regRdata <= wakeCount_reg[7:0];
        `WRCB_WCNT_HI_ADDR: regRdata <= wakeCount_reg[15:8];
        `WRCB_WLIM_LO_ADDR: regRdata <= wakeLimit_reg[7:0];
        `WRCB_WLIM_HI_ADDR: regRdata <= wakeLimit_reg[15:8];
        `WRCB_LISTEN_ADDR: regRdata <= listenPeriod_reg;
        `WRCB_TICKDIV_ADDR: regRdata <= tickDiv_reg;
        `WRCB_LEVEL_ADDR: regRdata <= levelLimit_reg;
        `WRCB_CARRIER0_ADDR: regRdata <= carrier_reg[7:0];
        `WRCB_CARRIER1_ADDR: regRdata <= carrier_reg[15:8];
        `WRCB_CARRIER2_ADDR: regRdata <= carrier_reg[23:16];
        `WRCB_RATE_LO_ADDR: regRdata <= rate_reg[7:0];
        `WRCB_RATE_HI_ADDR: regRdata <= {rateHiRest_reg, rate_reg[11:8]};
        default: regRdata <= 8'h00;
      endcase
    end
  end

  assign regHit = (regAddr >= `WRCB_IRQ_MASK0_ADDR) && (regAddr <= `WRCB_RATE_HI_ADDR);

  // wake sequencing: sleep, listen for the dwell period, or radio idle
  // a count past the limit always lands in radio idle, even mid-listen
  // divider or period of zero behaves as one
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_SLEEP: begin
        if (limitReach)
          state_next = ST_IDLE;
        else if (expiryPulse && smartWakeEn)
          state_next = ST_LISTEN;
      end
      ST_LISTEN: begin
        if (limitReach)
          state_next = ST_IDLE;
        else if (preambleFound)
          state_next = ST_IDLE;
        else if (dwellEnd)
          state_next = ST_SLEEP;
      end
      ST_IDLE: begin
        if (expiryPulse && smartWakeEn && !limitReach)
          state_next = ST_LISTEN;
      end
      default: state_next = ST_SLEEP;
    endcase
  end

  // state register
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_SLEEP;
    end else begin
      state_reg <= state_next;
    end
  end

  // radio control outputs, registered from the next state
  always @(posedge clk) begin
    if (rst) begin
      radioRxOn <= 1'b0;
      radioIdleWake <= 1'b0;
      sleepReq <= 1'b0;
    end else begin
      radioRxOn <= (state_next == ST_LISTEN);
      radioIdleWake <= (state_next == ST_IDLE);
      sleepReq <= (state_reg == ST_LISTEN) && (state_next == ST_SLEEP);
    end
  end

  // wake limit source: sticky until the host rewrites the count, a new hit wins
  always @(posedge clk) begin
    if (rst) begin
      limitHit_reg <= 1'b0;
    end else if (limitReach) begin
      limitHit_reg <= 1'b1;
    end else if (countWrite) begin
      limitHit_reg <= 1'b0;
    end
  end

  // listen timers: reference units, ticks of the divider, dwell count
  always @(posedge clk) begin
    if (rst) begin
      unitCnt_reg <= 32'd0;
      tickCnt_reg <= 8'h00;
      dwellCnt_reg <= 8'h00;
    end else if (state_reg != ST_LISTEN) begin
      unitCnt_reg <= 32'd0;
      tickCnt_reg <= 8'h00;
      dwellCnt_reg <= 8'h00;
    end else if (tickDone) begin
      unitCnt_reg <= 32'd0;
      if (stepReached(tickCnt_reg, tickDiv_reg)) begin
        tickCnt_reg <= 8'h00;
        dwellCnt_reg <= dwellCnt_reg + 8'h01;
      end else begin
        tickCnt_reg <= tickCnt_reg + 8'h01;
      end
    end else begin
      unitCnt_reg <= unitCnt_reg + 32'd1;
    end
  end

endmodule // wrcb_bank
`default_nettype wire

/* hw/wrcb_map.vh */
// register map, field positions and timing figures of the wake and radio configuration bank
// included by the bank module; definitions only
`ifndef WRCB_MAP_VH
`define WRCB_MAP_VH
// byte offsets on the serial control port address space
`define WRCB_IRQ_MASK0_ADDR 10'h100
`define WRCB_IRQ_MASK1_ADDR 10'h101
`define WRCB_WCNT_LO_ADDR 10'h102
`define WRCB_WCNT_HI_ADDR 10'h103
`define WRCB_WLIM_LO_ADDR 10'h104
`define WRCB_WLIM_HI_ADDR 10'h105
`define WRCB_LISTEN_ADDR 10'h106
`define WRCB_TICKDIV_ADDR 10'h107
`define WRCB_LEVEL_ADDR 10'h108
`define WRCB_CARRIER0_ADDR 10'h109
`define WRCB_CARRIER1_ADDR 10'h10a
`define WRCB_CARRIER2_ADDR 10'h10b
`define WRCB_RATE_LO_ADDR 10'h10c
`define WRCB_RATE_HI_ADDR 10'h10d
// mask bit positions
`define WRCB_M0_WAKE_LIMIT 7
`define WRCB_M1_BATTERY 7
`define WRCB_M1_CMD_READY 6
`define WRCB_M1_WAKE_TIMER 4
`define WRCB_M1_PORT_READY 1
`define WRCB_M1_CMD_DONE 0
`define WRCB_M1_WRITABLE 8'hd3
// reset values
`define WRCB_RESET_BYTE 8'h00
// listen tick: 128 periods of the 6.5 MHz reference per divider unit
`define WRCB_TICK_REF_CYCLES 128
`define WRCB_REF_KHZ 6500
`define WRCB_CLK_KHZ 250000
`endif

/* bench/wrcb_checker.sv */
// port assertions of the config bank
// assumes one clock, bound into wrcb_bank
`timescale 1ns/10ps
`default_nettype none
module wrcb_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [9:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // sources and results
  input wire logic batteryLow,
  input wire logic cmdReady,
  input wire logic portReady,
  input wire logic wakeTimerExpiry,
  input wire logic cmdDone,
  input wire logic radioRxOn,
  input wire logic sleepReq,
  input wire logic irqOut,
  input wire logic [23:0] carrierWord,
  input wire logic [11:0] bitRateWord,
  input wire logic signed [8:0] levelLimitDbm
);
  logic [7:0] maskHi;
  // shadow of the second mask, same edge as the bank
  always_ff @(posedge clk)
    if (rst) maskHi <= 8'h00;
    else if (regWrite && regAddr == 10'h101) maskHi <= regWdata & 8'hd3;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  battery_irq_a: assert property (batteryLow && maskHi[7] |-> irqOut) else $error("no irq");
  ready_irq_a: assert property (cmdReady && maskHi[6] |-> irqOut) else $error("no irq");
  port_irq_a: assert property (portReady && maskHi[1] |-> irqOut) else $error("no irq");
  timer_irq_a: assert property (wakeTimerExpiry && maskHi[4] |-> irqOut) else $error("no irq");
  done_irq_a: assert property (cmdDone && maskHi[0] |-> irqOut) else $error("no irq");
  mask_read_a: assert property (regRead && regAddr == 10'h101 |=> regRdata == maskHi)
    else $error("mask read");
  carrier_top_a: assert property (regWrite && regAddr == 10'h10b |=>
    carrierWord[23:16] == $past(regWdata)) else $error("carrier byte");
  rate_nibble_a: assert property (regWrite && regAddr == 10'h10d |=>
    {4'h0, bitRateWord[11:8]} == ($past(regWdata) & 8'h0f)) else $error("rate nibble");
  level_limit_a: assert property (regWrite && regAddr == 10'h108 |=>
    levelLimitDbm == $signed({1'b0, $past(regWdata)}) - 9'sd107) else $error("level");
  sleep_after_rx_a: assert property ($rose(sleepReq) |-> $past(radioRxOn))
    else $error("sleep without listen");
  sleep_pulse_a: assert property (sleepReq |=> !sleepReq) else $error("long sleep");
  cover property ($rose(sleepReq));
  cover property (batteryLow && maskHi[7] && irqOut);
  cover property (regRead && regAddr == 10'h101);
  cover property (wakeTimerExpiry && maskHi[4] && irqOut);
endmodule // wrcb_checker
`default_nettype wire

/* bench/wrcb_host.sv */
// host model on the bank's byte register port
// assumes one clock, requests launched at the falling edge
`timescale 1ns/10ps
`default_nettype none
module wrcb_host (
  // clock
  input wire logic clk,
  // register port
  output var logic [9:0] regAddr,
  output var logic regWrite,
  output var logic regRead,
  output var logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  // idle port at time zero
  initial begin
    {regAddr, regWrite, regRead, regWdata} = '0;
  end
  // one-cycle write strobe, reserved mask bits sent as zero
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = (a == 10'h101) ? d & 8'hd3 : d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regWdata = ~regWdata;
  endtask
  // read strobe, data taken at the falling edge half a cycle after the read edge
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    d = regRdata;
  endtask
endmodule // wrcb_host
`default_nettype wire

/* bench/wake_and_radio_config_bank_test.sv */
// self-checking bench of the config bank
// assumes wrcb_bank, wrcb_host and wrcb_checker compiled first
`timescale 1ns/10ps
`default_nettype none
module wake_and_radio_config_bank_test;
  logic clk, rst, batteryLow, cmdReady, portReady, cmdDone, wakeTimerExpiry;
  logic smartWakeEn, preambleFound;
  wire [9:0] regAddr;
  wire [7:0] regWdata, regRdata;
  wire regWrite, regRead, regHit, radioRxOn, radioIdleWake, sleepReq, irqOut;
  wire [23:0] carrierWord;
  wire [11:0] bitRateWord;
  wire signed [8:0] levelLimitDbm;
  integer errors = 0, cmp_count = 0, seed = 32'h75fd5af6, i, n;
  integer tick = 128 * 250000 / 6500;
  logic [7:0] expReg [0:13];
  logic [7:0] got;
  wrcb_host host (.clk, .regAddr, .regWrite, .regRead, .regWdata, .regRdata);
  wrcb_bank dut (.clk, .rst, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regHit,
    .batteryLow, .cmdReady, .portReady, .cmdDone, .wakeTimerExpiry, .smartWakeEn,
    .preambleFound, .radioRxOn, .radioIdleWake, .sleepReq, .irqOut, .carrierWord,
    .bitRateWord, .levelLimitDbm);
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one wake timer expiry
  task automatic expire;
    @(negedge clk) wakeTimerExpiry = 1'b1;
    @(negedge clk) wakeTimerExpiry = 1'b0;
  endtask
  // main sequence
  initial begin
    {batteryLow, cmdReady, portReady, cmdDone, wakeTimerExpiry, smartWakeEn, preambleFound} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (i = 0; i < 14; i++) begin
      host.rd(10'h100 + 10'(i), got);
      chk("reset byte", 8'h00, got);
    end
    chk("hit in map", 1'b1, regHit);
    $display("reset values done");
    for (i = 0; i < 15; i++) begin
      got = 8'($random(seed));
      host.wr(10'h100 + 10'(i), got);
      if (i < 14) expReg[i] = (i == 1) ? got & 8'hd3 : got;
    end
    for (i = 0; i < 15; i++) begin
      host.rd(10'h100 + 10'(i), got);
      chk("readback", i < 14 ? expReg[i] : 8'h00, got);
    end
    chk("hit out of map", 1'b0, regHit);
    chk("carrier", {expReg[11], expReg[10], expReg[9]}, carrierWord);
    chk("rate", {expReg[13][3:0], expReg[12]}, bitRateWord);
    chk("level", int'(expReg[8]) - 107, 32'(levelLimitDbm));
    $display("random readback done");
    host.wr(10'h100, 8'h00);
    for (n = 0; n < 4; n++) begin
      host.wr(10'h101, 8'h00);
      {batteryLow, cmdReady, portReady, cmdDone} = 4'b1000 >> n;
      @(negedge clk);
      chk("irq masked", 1'b0, irqOut);
      host.wr(10'h101, n < 2 ? 8'h80 >> n : 8'h02 >> (n - 2));
      chk("irq enabled", 1'b1, irqOut);
    end
    {batteryLow, cmdReady, portReady, cmdDone} = 4'b0000;
    $display("irq masks done");
    host.wr(10'h102, 8'h00);
    host.wr(10'h103, 8'h00);
    host.wr(10'h104, 8'h02);
    host.wr(10'h105, 8'h00);
    host.wr(10'h100, 8'h80);
    for (n = 1; n <= 3; n++) begin
      expire();
      host.rd(10'h102, got);
      chk("wake count", n, got);
      chk("idle wake", n > 2, radioIdleWake);
    end
    chk("limit irq", 1'b1, irqOut);
    $display("wake limit done");
    host.wr(10'h104, 8'hff);
    host.wr(10'h105, 8'hff);
    host.wr(10'h102, 8'h00);
    host.wr(10'h106, 8'h01);
    host.wr(10'h107, 8'h01);
    host.wr(10'h101, 8'h10);
    @(negedge clk) wakeTimerExpiry = 1'b1;
    #1 chk("timer irq", 1'b1, irqOut);
    @(negedge clk) wakeTimerExpiry = 1'b0;
    smartWakeEn = 1'b1;
    expire();
    chk("listening", 1'b1, radioRxOn);
    for (n = 0; n < 6000 && sleepReq !== 1'b1; n++) @(negedge clk);
    if (n == 6000) chk("sleep wait", 1, 0);
    else chk("listen length", 1, n >= tick - 4 && n <= tick + 2);
    preambleFound = 1'b1;
    expire();
    for (n = 0; n < 6000 && sleepReq !== 1'b1; n++) @(negedge clk);
    chk("no sleep on preamble", 6000, n);
    $display("listen done");
    give_verdict();
  end
endmodule // wake_and_radio_config_bank_test
bind wrcb_bank wrcb_checker mon (.clk, .rst, .regAddr, .regWrite, .regRead, .regWdata,
  .regRdata, .batteryLow, .cmdReady, .portReady, .wakeTimerExpiry, .cmdDone, .radioRxOn,
  .sleepReq, .irqOut,
  .carrierWord, .bitRateWord, .levelLimitDbm);
`default_nettype wire
